// file: core/epiu_map.svh
`ifndef EPIU_MAP_SVH
`define EPIU_MAP_SVH

// Register indices; byte address is four times the index
`define EPIU_IDX_MASK_LOW 6'h0f
`define EPIU_IDX_MASK_HIGH 6'h10
`define EPIU_IDX_GRP_FLAGS 6'h11
`define EPIU_IDX_GRP_EN 6'h12
`define EPIU_IDX_EXT_EN 6'h13
`define EPIU_IDX_EXT_FLAG 6'h14
`define EPIU_IDX_SENSE 6'h15

// Field positions
`define EPIU_BIT_EXT 0
`define EPIU_BIT_GRP_LOW 0
`define EPIU_BIT_GRP_HIGH 1
`define EPIU_SENSE_LSB 0

// Reset value of every register
`define EPIU_RST_VAL 8'h00

// Vector addresses of the three requests
`define EPIU_VEC_NONE 10'h000
`define EPIU_VEC_EXT 10'h001
`define EPIU_VEC_LOW 10'h002
`define EPIU_VEC_HIGH 10'h003

// Documented pin counts of the two change groups
`define EPIU_NUM_LOW 8
`define EPIU_NUM_HIGH 4

`endif

// file: core/epiu_pkg.sv
package epiu_pkg;

  // Sense select encodings of the dedicated pin
  typedef enum logic [1:0] {
    EPIU_SENSE_LOW = 2'b00,
    EPIU_SENSE_ANY = 2'b01,
    EPIU_SENSE_FALL = 2'b10,
    EPIU_SENSE_RISE = 2'b11
  } epiu_sense_e;

  // Register bus slave states
  typedef enum logic {
    EPIU_BUS_IDLE = 1'b0,
    EPIU_BUS_ACK = 1'b1
  } epiu_bus_e;

  typedef logic [7:0] epiu_byte_t;

endpackage

// file: core/epiu_top.sv
// Function
// - Sense 00 low level, 01 any change
// - Sense 10 falling edge, 11 rising edge
// - Pin sampled before edges; long pulses caught
// - Pin request needs enable bit and global flag
// - Pin activity requests even when pin drives
// - Edge or change sets pin pending flag
// - Pin flag clears on entry or written one
// - Low level mode holds pin flag cleared
// - Upper group enable plus global gives request
// - Lower group enable plus global gives request
// - Group change sets its group pending flag
// - Group flag clears on entry or one
// - Lower mask bits enable each lower pin
// - Upper mask bits 0-3, rest unused
// - All seven registers reset to zero
// - Change and level detection usable for wake
// - Vectors 0x001, 0x002, 0x003
`timescale 1ns/10ps
`default_nettype none
`include "epiu_map.svh"

module epiu_top
  import epiu_pkg::*;
#(
  parameter int NUM_LOW = `EPIU_NUM_LOW,
  parameter int NUM_HIGH = `EPIU_NUM_HIGH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_irq_pin,
  input wire logic [NUM_LOW+NUM_HIGH-1:0] change_input,
  input wire logic cpu_irq_enable,
  input wire logic enter_ext,
  input wire logic enter_low,
  input wire logic enter_high,
  output logic req_ext,
  output logic group_low_vector,
  output logic group_high_vector,
  output logic irq,
  output logic [9:0] irq_vector,
  output logic wake_req
);

  localparam int NUM_ALL = NUM_LOW + NUM_HIGH;

  // Mask registers are one byte each, so a group cannot exceed eight pins
  if (NUM_LOW < 1 || NUM_LOW > 8 || NUM_HIGH < 1 || NUM_HIGH > 8) begin : g_bad_param
    $error("epiu_top: group widths must be 1 to 8");
  end

  // Register state
  epiu_sense_e sense_q, sense_d;
  logic ext_en_q, ext_en_d;
  logic ext_flag_q, ext_flag_d;
  logic [1:0] grp_en_q, grp_en_d;
  logic [1:0] grp_flag_q, grp_flag_d;
  logic [NUM_LOW-1:0] mask_low_q, mask_low_d;
  logic [NUM_HIGH-1:0] mask_high_q, mask_high_d;
  epiu_bus_e bus_q, bus_d;
  logic [31:0] dat_q, dat_d;
  logic [9:0] vec_q, vec_d;

  // Synchronisers and previous samples
  logic ext_s1_q, ext_s2_q, ext_prev_q;
  logic [NUM_ALL-1:0] chg_s1_q, chg_s2_q, chg_prev_q;

  // Bus decode
  wire [5:0] reg_idx = wb_adr_i[7:2];
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_start = bus_req & (bus_q == EPIU_BUS_IDLE);
  wire wr_lane = bus_req & wb_we_i & wb_sel_i[0] & (bus_q == EPIU_BUS_ACK);
  wire [7:0] wr_byte = wb_dat_i[7:0];
  wire hit_mask_low = reg_idx == `EPIU_IDX_MASK_LOW;
  wire hit_mask_high = reg_idx == `EPIU_IDX_MASK_HIGH;
  wire hit_grp_flags = reg_idx == `EPIU_IDX_GRP_FLAGS;
  wire hit_grp_en = reg_idx == `EPIU_IDX_GRP_EN;
  wire hit_ext_en = reg_idx == `EPIU_IDX_EXT_EN;
  wire hit_ext_flag = reg_idx == `EPIU_IDX_EXT_FLAG;
  wire hit_sense = reg_idx == `EPIU_IDX_SENSE;
  wire wr_mask_low = wr_lane & hit_mask_low;
  wire wr_mask_high = wr_lane & hit_mask_high;
  wire wr_grp_flags = wr_lane & hit_grp_flags;
  wire wr_grp_en = wr_lane & hit_grp_en;
  wire wr_ext_en = wr_lane & hit_ext_en;
  wire wr_ext_flag = wr_lane & hit_ext_flag;
  wire wr_sense = wr_lane & hit_sense;

  // Read mux; unused bits and unmapped addresses read as zero
  epiu_byte_t rd_mask_low, rd_mask_high, rd_byte;
  assign rd_mask_low = epiu_byte_t'(mask_low_q);
  assign rd_mask_high = epiu_byte_t'(mask_high_q);
  assign rd_byte = hit_mask_low ? rd_mask_low :
                   hit_mask_high ? rd_mask_high :
                   hit_grp_flags ? {6'h00, grp_flag_q} :
                   hit_grp_en ? {6'h00, grp_en_q} :
                   hit_ext_en ? {7'h00, ext_en_q} :
                   hit_ext_flag ? {7'h00, ext_flag_q} :
                   hit_sense ? {6'h00, sense_q} : 8'h00;

  // Slave answers one cycle after the request, for one cycle only
  // Ack is held off while ce is low, so the master never leaves before the write lands
  assign bus_d = bus_start ? EPIU_BUS_ACK : EPIU_BUS_IDLE;
  assign dat_d = bus_start ? {24'h000000, rd_byte} : dat_q;
  assign wb_ack_o = (bus_q == EPIU_BUS_ACK) & ce;
  assign wb_dat_o = dat_q;

  // Dedicated pin: pad value is sampled whatever the pin direction
  wire ext_cur = ext_s2_q;
  wire ext_rise = ext_cur & ~ext_prev_q;
  wire ext_fall = ~ext_cur & ext_prev_q;
  logic ext_trig;
  always_comb begin
    case (sense_q)
      EPIU_SENSE_LOW: ext_trig = 1'b0;
      EPIU_SENSE_ANY: ext_trig = ext_rise | ext_fall;
      EPIU_SENSE_FALL: ext_trig = ext_fall;
      EPIU_SENSE_RISE: ext_trig = ext_rise;
      default: ext_trig = 1'b0;
    endcase
  end
  wire level_mode = sense_q == EPIU_SENSE_LOW;
  // Level request lasts only while the pin is low; the source must hold it
  wire level_req = level_mode & ~ext_cur;

  // Pin flag: a new event wins over a clear in the same cycle
  wire ext_clr = enter_ext | (wr_ext_flag & wr_byte[`EPIU_BIT_EXT]);
  assign ext_flag_d = level_mode ? 1'b0 :
                      ext_trig ? 1'b1 :
                      ext_clr ? 1'b0 : ext_flag_q;

  // Change groups: masked change per pin, ORed into a group trigger
  wire [NUM_ALL-1:0] chg = chg_s2_q ^ chg_prev_q;
  wire [NUM_LOW-1:0] chg_low = chg[NUM_LOW-1:0] & mask_low_q;
  wire [NUM_HIGH-1:0] chg_high = chg[NUM_ALL-1:NUM_LOW] & mask_high_q;
  wire trig_low = |chg_low;
  wire trig_high = |chg_high;
  wire [1:0] grp_trig = {trig_high, trig_low};
  wire [1:0] grp_wclr = wr_grp_flags ? wr_byte[1:0] : 2'b00;
  wire [1:0] grp_clr = grp_wclr | {enter_high, enter_low};
  assign grp_flag_d = grp_trig | (grp_flag_q & ~grp_clr);

  // Software writes into control registers
  assign sense_d = wr_sense ? epiu_sense_e'(wr_byte[`EPIU_SENSE_LSB +: 2]) : sense_q;
  assign ext_en_d = wr_ext_en ? wr_byte[`EPIU_BIT_EXT] : ext_en_q;
  assign grp_en_d = wr_grp_en ? wr_byte[1:0] : grp_en_q;
  assign mask_low_d = wr_mask_low ? wr_byte[NUM_LOW-1:0] : mask_low_q;
  assign mask_high_d = wr_mask_high ? wr_byte[NUM_HIGH-1:0] : mask_high_q;

  // Requests are gated by their enable and the global interrupt flag
  wire ext_pend = level_mode ? level_req : ext_flag_q;
  assign req_ext = ext_pend & ext_en_q & cpu_irq_enable;
  assign group_low_vector = grp_flag_q[`EPIU_BIT_GRP_LOW] &
                            grp_en_q[`EPIU_BIT_GRP_LOW] & cpu_irq_enable;
  assign group_high_vector = grp_flag_q[`EPIU_BIT_GRP_HIGH] &
                             grp_en_q[`EPIU_BIT_GRP_HIGH] & cpu_irq_enable;
  assign irq = req_ext | group_low_vector | group_high_vector;

  // Lowest vector address wins when several requests stand
  assign vec_d = req_ext ? `EPIU_VEC_EXT :
                 group_low_vector ? `EPIU_VEC_LOW :
                 group_high_vector ? `EPIU_VEC_HIGH : `EPIU_VEC_NONE;
  assign irq_vector = vec_q;

  // Wake from the synchronised path; true clockless sensing lives in the pad ring
  assign wake_req = (ext_en_q & level_req) |
                    (grp_en_q[`EPIU_BIT_GRP_LOW] & trig_low) |
                    (grp_en_q[`EPIU_BIT_GRP_HIGH] & trig_high);

  // Two-flop synchronisers, then one previous sample for edge detection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      ext_prev_q <= 1'b1;
      chg_s1_q <= '0;
      chg_s2_q <= '0;
      chg_prev_q <= '0;
    end else if (ce) begin
      ext_s1_q <= ext_irq_pin;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      chg_s1_q <= change_input;
      chg_s2_q <= chg_s1_q;
      chg_prev_q <= chg_s2_q;
    end
  end

  // Control, mask and flag registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sense_q <= EPIU_SENSE_LOW;
      ext_en_q <= 1'b0;
      ext_flag_q <= 1'b0;
      grp_en_q <= 2'b00;
      grp_flag_q <= 2'b00;
      mask_low_q <= '0;
      mask_high_q <= '0;
    end else if (ce) begin
      sense_q <= sense_d;
      ext_en_q <= ext_en_d;
      ext_flag_q <= ext_flag_d;
      grp_en_q <= grp_en_d;
      grp_flag_q <= grp_flag_d;
      mask_low_q <= mask_low_d;
      mask_high_q <= mask_high_d;
    end
  end

  // Bus slave and vector output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_q <= EPIU_BUS_IDLE;
      dat_q <= 32'h00000000;
      vec_q <= `EPIU_VEC_NONE;
    end else if (ce) begin
      bus_q <= bus_d;
      dat_q <= dat_d;
      vec_q <= vec_d;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_level_any_req: assert property (
    level_mode && !ext_cur && ext_en_q && cpu_irq_enable |-> req_ext)
    else $error("level low with enable gave no pin request");

  a_any_sets_flag: assert property (
    ce && sense_q == EPIU_SENSE_ANY && $changed(ext_cur) && !wr_sense
    |=> ext_flag_q)
    else $error("pin change in any-change mode did not set flag");

  a_fall_sets_flag: assert property (
    ce && sense_q == EPIU_SENSE_FALL && ext_prev_q && !ext_cur && !wr_sense
    |=> ext_flag_q)
    else $error("falling edge did not set pin flag");

  a_rise_only_edge: assert property (
    ce && sense_q == EPIU_SENSE_RISE && !ext_flag_q && !(ext_cur && !ext_prev_q)
    |=> !ext_flag_q)
    else $error("pin flag set without rising edge");

  a_pulse_caught: assert property (
    ce && sense_q == EPIU_SENSE_FALL && !wr_sense && !ext_clr
    ##1 ce && ext_s1_q && !ext_irq_pin
    ##1 ce [*2] |=> ext_flag_q)
    else $error("sampled falling pin not flagged within synchroniser delay");

  a_ext_gated: assert property (
    req_ext |-> ext_en_q && cpu_irq_enable)
    else $error("pin request without enable and global flag");

  a_flag_entry_clr: assert property (
    ce && enter_ext && !ext_trig && !wr_sense |=> !ext_flag_q)
    else $error("pin flag not cleared on routine entry");

  a_flag_set_wins: assert property (
    ce && ext_trig && ext_clr && !level_mode |=> ext_flag_q)
    else $error("clear beat a same-cycle pin event");

  a_level_no_flag: assert property (
    ce && level_mode |=> !ext_flag_q)
    else $error("pin flag set in level mode");

  a_high_gated: assert property (
    group_high_vector |-> grp_en_q[1] && cpu_irq_enable && grp_flag_q[1])
    else $error("upper group request without enable");

  a_low_gated: assert property (
    group_low_vector |-> grp_en_q[0] && cpu_irq_enable && grp_flag_q[0])
    else $error("lower group request without enable");

  a_group_set: assert property (
    ce && (|(chg[NUM_LOW-1:0] & mask_low_q)) |=> grp_flag_q[0])
    else $error("masked lower change did not set group flag");

  a_group_w1c: assert property (
    ce && wr_grp_flags && wr_byte[1] && !trig_high |=> !grp_flag_q[1])
    else $error("upper group flag not cleared by written one");

  a_mask_blocks: assert property (
    ce && mask_low_q == '0 && !grp_flag_q[0] |=> !grp_flag_q[0])
    else $error("lower group flag set with all pins masked");

  a_vector_map: assert property (
    ce && req_ext |=> vec_q == `EPIU_VEC_EXT)
    else $error("pin request did not present its vector");

  a_bus_ack: assert property (
    ce && bus_start ##1 ce |-> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");

  a_high_group_set: assert property (
    ce && (|(chg[NUM_ALL-1:NUM_LOW] & mask_high_q)) |=> grp_flag_q[1])
    else $error("masked upper change did not set group flag");

  a_low_w1c: assert property (
    ce && wr_grp_flags && wr_byte[0] && !trig_low |=> !grp_flag_q[0])
    else $error("lower group flag not cleared by written one");

  a_entry_grp_clr: assert property (
    ce && enter_high && !trig_high |=> !grp_flag_q[1])
    else $error("upper group flag not cleared on routine entry");

  a_pin_w1c: assert property (
    ce && wr_ext_flag && wr_byte[0] && !ext_trig |=> !ext_flag_q)
    else $error("pin flag not cleared by written one");

  a_vec_low: assert property (
    ce && !req_ext && group_low_vector |=> vec_q == `EPIU_VEC_LOW)
    else $error("lower group request did not present its vector");

  a_ce_freeze: assert property (
    !ce |=> $stable(ext_flag_q) && $stable(grp_flag_q) && $stable(bus_q))
    else $error("state moved while clock enable was low");

  a_low_entry_clr: assert property (
    ce && enter_low && !trig_low |=> !grp_flag_q[0])
    else $error("lower group flag not cleared on routine entry");

  c_fall_flag: cover property (sense_q == EPIU_SENSE_FALL && $rose(ext_flag_q));
  c_high_req: cover property ($rose(group_high_vector));
  c_level_req: cover property (level_mode && $rose(req_ext));
  c_bus_write: cover property (wr_lane && hit_mask_low);
  c_group_entry: cover property (enter_low && grp_flag_q[0]);

endmodule // epiu_top

`default_nettype wire

// file: dv/epiu_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

// CPU vectoring stand-in: enters the highest-priority pending routine
module epiu_cpu_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic auto_en,
  input wire logic req_ext,
  input wire logic group_low_vector,
  input wire logic group_high_vector,
  output logic enter_ext,
  output logic enter_low,
  output logic enter_high
);
  logic busy_q;

  // One-cycle entry pulse, then a gap so a clearing flag is not entered twice
  always_ff @(posedge ref_clk) begin
    if (rst || busy_q) begin
      enter_ext <= 1'b0;
      enter_low <= 1'b0;
      enter_high <= 1'b0;
      busy_q <= 1'b0;
    end else if (auto_en && (req_ext || group_low_vector || group_high_vector)) begin
      enter_ext <= req_ext;
      enter_low <= !req_ext && group_low_vector;
      enter_high <= !req_ext && !group_low_vector && group_high_vector;
      busy_q <= 1'b1;
    end
  end
endmodule // epiu_cpu_model

`default_nettype wire

// file: dv/epiu_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "epiu_map.svh"

module epiu_tb_top import epiu_pkg::*;;
  logic ref_clk = 0, rst = 1, ce = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, ext_irq_pin = 1, cpu_irq_enable = 0, auto_en = 0, wake_req;
  logic [11:0] change_input = '0;
  logic enter_ext, enter_low, enter_high, req_ext, group_low_vector, group_high_vector, irq;
  logic [9:0] irq_vector;
  int fail_count = 0, checked = 0, cycles = 0, n_ext = 0;

  epiu_top dut_u (.ref_clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_irq_pin, .change_input,
    .cpu_irq_enable, .enter_ext, .enter_low, .enter_high, .req_ext, .group_low_vector,
    .group_high_vector, .irq, .irq_vector, .wake_req);
  epiu_cpu_model cpu_u (.ref_clk, .rst, .auto_en, .req_ext, .group_low_vector,
    .group_high_vector, .enter_ext, .enter_low, .enter_high);

  always #12.5 ref_clk = ~ref_clk;

  // Hang guard; the run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    n_ext += enter_ext;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string nm);
    logic [7:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk(nm, {2'b00, exp}, {2'b00, q});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  initial begin
    wt(10);
    rst <= 0;
    for (int i = 15; i <= 21; i++) rd(i[5:0], 8'h00, "reset value");
    rd(6'h00, 8'h00, "unmapped");
    wr(`EPIU_IDX_MASK_HIGH, 8'hff);
    rd(`EPIU_IDX_MASK_HIGH, 8'h0f, "mask high");
    wr(`EPIU_IDX_EXT_EN, 8'h01);
    cpu_irq_enable <= 1;
    // Edge modes: the edge opposite the mode first (any-change mode flags it), then a two-cycle pulse
    for (int m = 1; m < 4; m++) begin
      ext_irq_pin <= (m == 3);
      wr(`EPIU_IDX_SENSE, m[7:0]);
      wt(4);
      wr(`EPIU_IDX_EXT_FLAG, 8'h01);
      ext_irq_pin <= ~ext_irq_pin;
      wt(5);
      rd(`EPIU_IDX_EXT_FLAG, {7'h0, m == 1}, "opposite edge");
      wr(`EPIU_IDX_EXT_FLAG, 8'h01);
      ext_irq_pin <= ~ext_irq_pin;
      wt(2);
      ext_irq_pin <= ~ext_irq_pin;
      wt(5);
      #1 chk("req_ext", 10'h001, {9'h0, req_ext});
      chk("vector", `EPIU_VEC_EXT, irq_vector);
      rd(`EPIU_IDX_EXT_FLAG, 8'h01, "pin flag");
      wr(`EPIU_IDX_EXT_FLAG, 8'h01);
      rd(`EPIU_IDX_EXT_FLAG, 8'h00, "flag w1c");
    end
    // Low level mode; a rising edge first leaves a flag that level mode must clear
    ext_irq_pin <= 1;
    wt(5);
    rd(`EPIU_IDX_EXT_FLAG, 8'h01, "rise before level");
    wr(`EPIU_IDX_SENSE, 8'h00);
    ext_irq_pin <= 0;
    wt(5);
    #1 chk("level req", 10'h001, {9'h0, req_ext});
    chk("level wake", 10'h001, {9'h0, wake_req});
    rd(`EPIU_IDX_EXT_FLAG, 8'h00, "level flag");
    cpu_irq_enable <= 0;
    wt(1);
    #1 chk("gated irq", 10'h000, {9'h0, irq});
    wt(1);
    cpu_irq_enable <= 1;
    ext_irq_pin <= 1;
    // Pin-change groups
    wr(`EPIU_IDX_GRP_EN, 8'h03);
    wr(`EPIU_IDX_MASK_LOW, 8'h08);
    change_input <= 12'h004;
    wt(5);
    rd(`EPIU_IDX_GRP_FLAGS, 8'h00, "masked pin");
    change_input <= 12'h00c;
    wt(5);
    rd(`EPIU_IDX_GRP_FLAGS, 8'h01, "low flag");
    change_input <= 12'h20c;
    wt(5);
    #1 chk("low vector", `EPIU_VEC_LOW, irq_vector);
    rd(`EPIU_IDX_GRP_FLAGS, 8'h03, "both flags");
    wr(`EPIU_IDX_GRP_FLAGS, 8'h01);
    wt(2);
    #1 chk("high vector", `EPIU_VEC_HIGH, irq_vector);
    rd(`EPIU_IDX_GRP_FLAGS, 8'h02, "group w1c");
    // Clock enable low: a masked-in change must wait until it is high again
    ce <= 0;
    change_input <= 12'h204;
    wt(5);
    #1 chk("frozen", 10'h000, {9'h0, group_low_vector});
    wt(1);
    ce <= 1;
    wt(5);
    rd(`EPIU_IDX_GRP_FLAGS, 8'h03, "thawed");
    // Routine entry by the CPU model clears flags
    auto_en <= 1;
    wr(`EPIU_IDX_SENSE, 8'h02);
    ext_irq_pin <= 0;
    change_input <= 12'h20c;
    wt(8);
    rd(`EPIU_IDX_GRP_FLAGS, 8'h00, "entry clear");
    rd(`EPIU_IDX_EXT_FLAG, 8'h00, "entry clear pin");
    chk("pin entries", 10'h001, n_ext[9:0]);
    wrap_up();
  end
endmodule // epiu_tb_top

`default_nettype wire
